/* include/vtpt_pkg.sv */
// Shared constants and types of the video test-pattern timing block
package vtpt_pkg;

  // Register offsets
  localparam logic [7:0] VTPT_CTL_OFS = 8'h01;
  localparam logic [7:0] VTPT_CFG_OFS = 8'h02;
  localparam logic [7:0] VTPT_DI_OFS = 8'h03;
  localparam logic [7:0] VTPT_LINE_HI_OFS = 8'h04;
  localparam logic [7:0] VTPT_LINE_LO_OFS = 8'h05;
  localparam logic [7:0] VTPT_BAR_HI_OFS = 8'h06;
  localparam logic [7:0] VTPT_BAR_LO_OFS = 8'h07;
  localparam logic [7:0] VTPT_ACT_HI_OFS = 8'h08;
  localparam logic [7:0] VTPT_ACT_LO_OFS = 8'h09;
  localparam logic [7:0] VTPT_TOT_HI_OFS = 8'h0A;
  localparam logic [7:0] VTPT_TOT_LO_OFS = 8'h0B;
  localparam logic [7:0] VTPT_PD_HI_OFS = 8'h0C;
  localparam logic [7:0] VTPT_PD_LO_OFS = 8'h0D;
  localparam logic [7:0] VTPT_TOP_OFS = 8'h0E;
  localparam logic [7:0] VTPT_BOT_OFS = 8'h0F;
  localparam logic [7:0] VTPT_LAST_OFS = 8'h0F;
  localparam int VTPT_NREG = 16;

  // Field positions
  localparam int VTPT_ON_BIT = 0;
  localparam int VTPT_SOLID_BIT = 7;
  localparam int VTPT_BARSEL_LSB = 4;
  localparam int VTPT_BLK_LSB = 0;
  localparam int VTPT_DT_LSB = 0;
  localparam int VTPT_VC_LSB = 6;

  // Reset values
  localparam logic [7:0] VTPT_CTL_RST = 8'h00;
  localparam logic [7:0] VTPT_CFG_RST = 8'h33;
  localparam logic [7:0] VTPT_DI_RST = 8'h24;
  localparam logic [7:0] VTPT_LINE_HI_RST = 8'h07;
  localparam logic [7:0] VTPT_LINE_LO_RST = 8'h80;
  localparam logic [7:0] VTPT_BAR_HI_RST = 8'h00;
  localparam logic [7:0] VTPT_BAR_LO_RST = 8'hF0;
  localparam logic [7:0] VTPT_ACT_HI_RST = 8'h01;
  localparam logic [7:0] VTPT_ACT_LO_RST = 8'hE0;
  localparam logic [7:0] VTPT_PD_HI_RST = 8'h0C;
  localparam logic [7:0] VTPT_PD_LO_RST = 8'h67;
  localparam logic [7:0] VTPT_BOT_RST = 8'h0A;
  localparam logic [15:0] VTPT_TOT_DEF = 16'h020D;
  localparam logic [7:0] VTPT_TOP_DEF = 8'h21;

  // Timing: line interval counts in 10 ns units, clock is 50 ns
  localparam int VTPT_UNIT_NS = 10;
  localparam int VTPT_CLK_NS = 50;
  localparam logic [16:0] VTPT_UNITS_PER_CLK =
    17'(VTPT_CLK_NS / VTPT_UNIT_NS);

  typedef enum logic [3:0] {
    VTPT_ST_OFF  = 4'b0001,
    VTPT_ST_WAIT = 4'b0010,
    VTPT_ST_DATA = 4'b0100,
    VTPT_ST_END  = 4'b1000
  } vtpt_state_t;

  // Video event and header bundle toward the transmit path
  typedef struct packed {
    logic fs;
    logic fe;
    logic ls;
    logic le;
    logic dvalid;
    logic [1:0] vc;
    logic [5:0] dt;
    logic [15:0] wc;
  } vtpt_vid_t;

  // Register write/read request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } vtpt_req_t;

  // Number of bars for the 2-bit select
  function automatic logic [3:0] vtpt_bar_total(input logic [1:0] sel);
    logic [3:0] n;
    n = 4'h1 << sel;
    return n;
  endfunction

endpackage

/* verilog/vtpt_line_timer.sv */
// Line-period tick generator in 10 ns units
`timescale 1ns/1ps
module vtpt_line_timer
  import vtpt_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Control
  input wire logic run_i,
  input wire logic [15:0] interval_i,
  // Tick
  output logic tick_o
);

  typedef struct packed {
    logic armed;
    logic [16:0] acc;
    logic tick;
  } vtpt_tmr_t;

  vtpt_tmr_t r;
  vtpt_tmr_t next_r;

  always_comb
  begin
    next_r = r;
    next_r.tick = 1'b0;
    if (!run_i)
    begin
      next_r.armed = 1'b0;
      next_r.acc = '0;
    end
    else if (!r.armed)
    begin
      // First line starts at once on enable
      next_r.armed = 1'b1;
      next_r.tick = 1'b1;
      next_r.acc = '0;
    end
    else if (r.acc + VTPT_UNITS_PER_CLK >= {1'b0, interval_i})
    begin
      // Remainder kept so the average period is exact
      next_r.tick = 1'b1;
      next_r.acc = r.acc + VTPT_UNITS_PER_CLK - {1'b0, interval_i};
    end
    else
    begin
      next_r.acc = r.acc + VTPT_UNITS_PER_CLK;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      r <= '0;
    else
      r <= next_r;
  end

  assign tick_o = r.tick;

endmodule

/* verilog/vtpt_bar_walker.sv */
// Colour index walker for bar and fixed patterns
`timescale 1ns/1ps
module vtpt_bar_walker
  import vtpt_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Line control
  input wire logic clear_i,
  input wire logic step_i,
  // Settings
  input wire logic solid_i,
  input wire logic [1:0] bar_sel_i,
  input wire logic [15:0] bar_bytes_i,
  input wire logic [3:0] block_i,
  // Index of the byte now on the output
  output logic [3:0] color_idx_o
);

  typedef struct packed {
    logic [3:0] idx;
    logic [15:0] cnt;
  } vtpt_walk_t;

  vtpt_walk_t r;
  vtpt_walk_t next_r;
  logic [3:0] last_bar;
  logic [3:0] blk;

  always_comb
  begin
    next_r = r;
    last_bar = vtpt_bar_total(bar_sel_i) - 4'h1;
    // Block size of zero is not allowed; treated as one
    blk = (block_i == 4'h0) ? 4'h1 : block_i;
    if (clear_i)
    begin
      next_r = '0;
    end
    else if (step_i)
    begin
      if (solid_i)
      begin
        next_r.idx = (r.idx + 4'h1 >= blk) ? 4'h0 : r.idx + 4'h1;
      end
      else if (r.idx != last_bar && {1'b0, r.cnt} + 17'h1 >=
               {1'b0, bar_bytes_i})
      begin
        next_r.idx = r.idx + 4'h1;
        next_r.cnt = '0;
      end
      else
      begin
        // Last bar runs to the end of the line
        next_r.cnt = r.cnt + 16'h1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      r <= '0;
    else
      r <= next_r;
  end

  assign color_idx_o = r.idx;

endmodule

/* verilog/vtpt_top.sv */
// Video test-pattern frame timing generator, top level
`timescale 1ns/1ps
module vtpt_top
  import vtpt_pkg::*;
#(
  parameter logic [15:0] FRAME_LINES_RST = VTPT_TOT_DEF,
  parameter logic [7:0] TOP_BLANK_RST = VTPT_TOP_DEF
)
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Register port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // Video stream toward the transmit path
  output vtpt_vid_t vid_o,
  output logic [3:0] color_idx_o,
  // Status
  output logic frame_busy_o
);

  typedef struct packed {
    logic [VTPT_NREG-1:0][7:0] regs;
    logic [7:0] rdata;
    vtpt_state_t st;
    logic pend;
    logic [15:0] line_idx;
    logic [15:0] left;
    logic busy;
    vtpt_vid_t vid;
  } vtpt_top_st_t;

  vtpt_top_st_t r;
  vtpt_top_st_t next_r;
  vtpt_req_t req;
  logic [1:0] rst_sync;
  logic rst_n;
  logic tick;
  logic run;
  logic [15:0] line_bytes;
  logic [15:0] bar_bytes;
  logic [15:0] act_lines;
  logic [15:0] tot_lines;
  logic [15:0] interval;
  logic [16:0] act_first;
  logic [16:0] act_end;
  logic [16:0] end_line;
  logic [16:0] idx_x;
  logic in_act;
  logic do_fs;
  logic do_fe;
  logic wrap;
  logic line_go;

  // Offsets outside the pattern page are ignored on write
  function automatic logic reg_hit(input logic [7:0] addr);
    return (addr >= VTPT_CTL_OFS) && (addr <= VTPT_LAST_OFS);
  endfunction

  // Read decode per offset; anything unmapped reads as zero
  function automatic logic [7:0] read_mux(
    input logic [VTPT_NREG-1:0][7:0] regs,
    input logic [7:0] addr
  );
    logic [7:0] d;
    d = 8'h00;
    if (addr == VTPT_CTL_OFS)
      d = regs[VTPT_CTL_OFS[3:0]];
    else if (addr == VTPT_CFG_OFS)
      d = regs[VTPT_CFG_OFS[3:0]];
    else if (addr == VTPT_DI_OFS)
      d = regs[VTPT_DI_OFS[3:0]];
    else if (addr == VTPT_LINE_HI_OFS)
      d = regs[VTPT_LINE_HI_OFS[3:0]];
    else if (addr == VTPT_LINE_LO_OFS)
      d = regs[VTPT_LINE_LO_OFS[3:0]];
    else if (addr == VTPT_BAR_HI_OFS)
      d = regs[VTPT_BAR_HI_OFS[3:0]];
    else if (addr == VTPT_BAR_LO_OFS)
      d = regs[VTPT_BAR_LO_OFS[3:0]];
    else if (addr == VTPT_ACT_HI_OFS)
      d = regs[VTPT_ACT_HI_OFS[3:0]];
    else if (addr == VTPT_ACT_LO_OFS)
      d = regs[VTPT_ACT_LO_OFS[3:0]];
    else if (addr == VTPT_TOT_HI_OFS)
      d = regs[VTPT_TOT_HI_OFS[3:0]];
    else if (addr == VTPT_TOT_LO_OFS)
      d = regs[VTPT_TOT_LO_OFS[3:0]];
    else if (addr == VTPT_PD_HI_OFS)
      d = regs[VTPT_PD_HI_OFS[3:0]];
    else if (addr == VTPT_PD_LO_OFS)
      d = regs[VTPT_PD_LO_OFS[3:0]];
    else if (addr == VTPT_TOP_OFS)
      d = regs[VTPT_TOP_OFS[3:0]];
    else if (addr == VTPT_BOT_OFS)
      d = regs[VTPT_BOT_OFS[3:0]];
    return d;
  endfunction

  // Reset release through two flops
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rst_sync <= 2'b00;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  assign req = '{wr: reg_wr_i, rd: reg_rd_i, addr: reg_addr_i,
                 wdata: reg_wdata_i};

  // Assembled settings
  assign line_bytes = {r.regs[VTPT_LINE_HI_OFS[3:0]],
                       r.regs[VTPT_LINE_LO_OFS[3:0]]};
  assign bar_bytes = {r.regs[VTPT_BAR_HI_OFS[3:0]],
                      r.regs[VTPT_BAR_LO_OFS[3:0]]};
  assign act_lines = {r.regs[VTPT_ACT_HI_OFS[3:0]],
                      r.regs[VTPT_ACT_LO_OFS[3:0]]};
  assign tot_lines = {r.regs[VTPT_TOT_HI_OFS[3:0]],
                      r.regs[VTPT_TOT_LO_OFS[3:0]]};
  assign interval = {r.regs[VTPT_PD_HI_OFS[3:0]],
                     r.regs[VTPT_PD_LO_OFS[3:0]]};
  assign run = r.regs[VTPT_CTL_OFS[3:0]][VTPT_ON_BIT];

  // Frame layout in line numbers
  assign act_first = {9'h000, r.regs[VTPT_TOP_OFS[3:0]]};
  assign act_end = act_first + {1'b0, act_lines};
  assign end_line = act_end + {9'h000, r.regs[VTPT_BOT_OFS[3:0]]};
  assign idx_x = {1'b0, r.line_idx};
  assign in_act = (idx_x >= act_first) && (idx_x < act_end);
  assign do_fs = (r.line_idx == 16'h0000);
  assign do_fe = (idx_x == end_line);
  // Wrap waits for frame end even if the total is set too short
  assign wrap = (idx_x + 17'h1 >= {1'b0, tot_lines}) &&
                (idx_x >= end_line);
  assign line_go = r.pend || tick;

  always_comb
  begin
    next_r = r;
    next_r.vid.fs = 1'b0;
    next_r.vid.fe = 1'b0;
    next_r.vid.ls = 1'b0;
    next_r.vid.le = 1'b0;
    next_r.vid.dvalid = 1'b0;

    // Register access
    if (req.wr && reg_hit(req.addr))
    begin
      next_r.regs[req.addr[3:0]] = req.wdata;
    end
    if (req.rd)
      next_r.rdata = read_mux(r.regs, req.addr);

    // A tick during a data burst is served once the burst ends
    if (tick && r.st != VTPT_ST_WAIT)
      next_r.pend = 1'b1;

    case (r.st)
      VTPT_ST_OFF:
      begin
        next_r.pend = 1'b0;
        next_r.line_idx = '0;
        next_r.busy = 1'b0;
        if (run)
          next_r.st = VTPT_ST_WAIT;
      end
      VTPT_ST_WAIT:
      begin
        if (line_go)
        begin
          next_r.pend = 1'b0;
          next_r.vid.fs = do_fs;
          next_r.vid.fe = do_fe;
          if (do_fs)
            next_r.busy = 1'b1;
          if (do_fe)
            next_r.busy = 1'b0;
          next_r.line_idx = wrap ? 16'h0000 : r.line_idx + 16'h0001;
          if (in_act)
          begin
            // Header fields are latched once per line
            next_r.vid.ls = 1'b1;
            next_r.vid.dt = r.regs[VTPT_DI_OFS[3:0]][VTPT_DT_LSB +: 6];
            next_r.vid.vc = r.regs[VTPT_DI_OFS[3:0]][VTPT_VC_LSB +: 2];
            next_r.vid.wc = line_bytes;
            next_r.left = line_bytes;
            next_r.st = VTPT_ST_DATA;
          end
        end
      end
      VTPT_ST_DATA:
      begin
        if (r.left != 16'h0000)
        begin
          next_r.vid.dvalid = 1'b1;
          next_r.left = r.left - 16'h0001;
        end
        else
        begin
          next_r.st = VTPT_ST_END;
        end
      end
      VTPT_ST_END:
      begin
        next_r.vid.le = 1'b1;
        next_r.st = VTPT_ST_WAIT;
      end
      default:
      begin
        next_r.st = VTPT_ST_OFF;
      end
    endcase

    // Clearing the enable stops the generator at once
    if (!run)
    begin
      next_r.st = VTPT_ST_OFF;
      next_r.vid.fs = 1'b0;
      next_r.vid.ls = 1'b0;
      next_r.vid.fe = 1'b0;
      next_r.vid.dvalid = 1'b0;
      next_r.vid.le = 1'b0;
      // Frame flag drops with the stream so no half frame looks open
      next_r.busy = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r <= '0;
      r.st <= VTPT_ST_OFF;
      r.regs[VTPT_CTL_OFS[3:0]] <= VTPT_CTL_RST;
      r.regs[VTPT_CFG_OFS[3:0]] <= VTPT_CFG_RST;
      r.regs[VTPT_DI_OFS[3:0]] <= VTPT_DI_RST;
      r.regs[VTPT_LINE_HI_OFS[3:0]] <= VTPT_LINE_HI_RST;
      r.regs[VTPT_LINE_LO_OFS[3:0]] <= VTPT_LINE_LO_RST;
      r.regs[VTPT_BAR_HI_OFS[3:0]] <= VTPT_BAR_HI_RST;
      r.regs[VTPT_BAR_LO_OFS[3:0]] <= VTPT_BAR_LO_RST;
      r.regs[VTPT_ACT_HI_OFS[3:0]] <= VTPT_ACT_HI_RST;
      r.regs[VTPT_ACT_LO_OFS[3:0]] <= VTPT_ACT_LO_RST;
      r.regs[VTPT_TOT_HI_OFS[3:0]] <= FRAME_LINES_RST[15:8];
      r.regs[VTPT_TOT_LO_OFS[3:0]] <= FRAME_LINES_RST[7:0];
      r.regs[VTPT_PD_HI_OFS[3:0]] <= VTPT_PD_HI_RST;
      r.regs[VTPT_PD_LO_OFS[3:0]] <= VTPT_PD_LO_RST;
      r.regs[VTPT_TOP_OFS[3:0]] <= TOP_BLANK_RST;
      r.regs[VTPT_BOT_OFS[3:0]] <= VTPT_BOT_RST;
      r.vid.dt <= VTPT_DI_RST[5:0];
    end
    else
    begin
      r <= next_r;
    end
  end

  vtpt_line_timer u_timer (
    .clk_i(sys_clk_i),
    .rst_n_i(rst_n),
    .run_i(run),
    .interval_i(interval),
    .tick_o(tick)
  );

  vtpt_bar_walker u_walker (
    .clk_i(sys_clk_i),
    .rst_n_i(rst_n),
    .clear_i(r.vid.ls),
    .step_i(r.vid.dvalid),
    .solid_i(r.regs[VTPT_CFG_OFS[3:0]][VTPT_SOLID_BIT]),
    .bar_sel_i(r.regs[VTPT_CFG_OFS[3:0]][VTPT_BARSEL_LSB +: 2]),
    .bar_bytes_i(bar_bytes),
    .block_i(r.regs[VTPT_CFG_OFS[3:0]][VTPT_BLK_LSB +: 4]),
    .color_idx_o(color_idx_o)
  );

  assign reg_rdata_o = r.rdata;
  assign vid_o = r.vid;
  assign frame_busy_o = r.busy;

endmodule

/* bench/vtpt_top_assertions.sv */
// Concurrent checks on the pattern timing outputs
`timescale 1ns/1ps
module vtpt_top_assertions
  import vtpt_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Register writes
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  // Video and status
  input wire vtpt_vid_t vid_o,
  input wire logic frame_busy_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_le_after_data: assert property (
    $fell(vid_o.dvalid) && frame_busy_o |=> vid_o.le)
    else $error("line end missing after last byte");
  a_ls_then_data: assert property (
    vid_o.ls && vid_o.wc != 16'h0000 |=> vid_o.dvalid)
    else $error("data did not follow line start");
  a_data_from_ls: assert property (
    $rose(vid_o.dvalid) |-> $past(vid_o.ls))
    else $error("data began without a line start");
  a_hdr_steady: assert property (vid_o.dvalid |->
    $stable(vid_o.dt) && $stable(vid_o.vc) && $stable(vid_o.wc))
    else $error("header changed during data");
  a_ls_in_frame: assert property (
    vid_o.ls |-> frame_busy_o || vid_o.fs)
    else $error("line start outside a frame");
  a_fs_opens: assert property (
    vid_o.fs |=> frame_busy_o && !vid_o.fs)
    else $error("frame start did not open a frame");
  a_fe_closes: assert property (
    vid_o.fe |=> !frame_busy_o && !vid_o.dvalid)
    else $error("frame still busy after frame end");
  a_stop_quiet: assert property (reg_wr_i &&
    reg_addr_i == VTPT_CTL_OFS && !reg_wdata_i[VTPT_ON_BIT]
    |-> ##2 !frame_busy_o && !vid_o.dvalid && !vid_o.fs)
    else $error("generator kept running after disable");
endmodule

bind vtpt_top vtpt_top_assertions u_chk (
  .sys_clk_i(sys_clk_i),
  .rst_n_i(rst_n_i),
  .reg_wr_i(reg_wr_i),
  .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i),
  .vid_o(vid_o),
  .frame_busy_o(frame_busy_o)
);

/* bench/vtpt_tx_sink.sv */
// Behavioural stand-in for the transmit path, logs stream timing
`timescale 1ns/1ps
module vtpt_tx_sink
  import vtpt_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Stream from the generator
  input wire vtpt_vid_t vid_i,
  input wire logic [3:0] idx_i
);
  logic [31:0] cyc = 0, n_fs = 0, n_ls = 0, t_fs = 0, t_fs0 = 0;
  logic [31:0] t_fe = 0, t_ls = 0, t_ls0 = 0, t_ls1 = 0, lines = 0;
  logic [31:0] nb = 0, line_bytes = 0, act = 0;
  logic [5:0] dt = 0;
  logic [1:0] vc = 0;
  logic [3:0] idx [0:63];
  // No back-pressure: the real path accepts a byte every clock
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (vid_i.fs)
    begin
      n_fs <= n_fs + 1;
      t_fs0 <= t_fs;
      t_fs <= cyc;
    end
    if (vid_i.fe)
    begin
      t_fe <= cyc;
      act <= lines;
    end
    if (vid_i.ls)
    begin
      n_ls <= n_ls + 1;
      lines <= vid_i.fs ? 1 : lines + 1;
      if (vid_i.fs || lines == 0)
        t_ls1 <= cyc;
      t_ls0 <= t_ls;
      t_ls <= cyc;
      nb <= 0;
      dt <= vid_i.dt;
      vc <= vid_i.vc;
    end
    else if (vid_i.fs)
      lines <= 0;
    if (vid_i.dvalid)
    begin
      idx[nb[5:0]] <= idx_i;
      nb <= nb + 1;
    end
    if (vid_i.le)
      line_bytes <= nb;
  end
endmodule

/* bench/tb.sv */
// Self-checking bench for the pattern timing block
`timescale 1ns/1ps
module tb import vtpt_pkg::*;;
  logic sys_clk_i = 0;
  logic rst_n_i = 0;
  logic reg_wr_i = 0;
  logic reg_rd_i = 0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic [7:0] reg_rdata_o;
  vtpt_vid_t vid_o;
  logic [3:0] color_idx_o;
  logic frame_busy_o;
  logic [31:0] seen_ls;
  int n_fail = 0;
  int cmp_count = 0;
  logic [7:0] rst_tab [1:15] = '{8'h00, 8'h33, 8'h24, 8'h07, 8'h80,
    8'h00, 8'hF0, 8'h01, 8'hE0, 8'h02, 8'h0D, 8'h0C, 8'h67, 8'h21, 8'h0A};
  // 16-byte lines, bars of 3, 2 active of 8 lines, top 1, bottom 2
  logic [7:0] set_tab [2:15] = '{8'h23, 8'h95, 8'h00, 8'h10, 8'h00,
    8'h03, 8'h00, 8'h02, 8'h00, 8'h08, 8'h0C, 8'h67, 8'h01, 8'h02};

  always #25 sys_clk_i = ~sys_clk_i;

  vtpt_top u_vtpt_top (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o),
    .vid_o(vid_o),
    .color_idx_o(color_idx_o),
    .frame_busy_o(frame_busy_o)
  );

  vtpt_tx_sink u_sink (.clk_i(sys_clk_i), .vid_i(vid_o), .idx_i(color_idx_o));

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, got);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, d);
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, exp);
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    @(negedge sys_clk_i);
    chk($sformatf("reg %0h", a), {24'h0, exp}, {24'h0, reg_rdata_o});
  endtask

  task automatic wait_fs(input int n);
    logic [31:0] tgt;
    tgt = u_sink.n_fs + 32'(n);
    for (int k = 0; k < 12000 && u_sink.n_fs != tgt; k++)
      @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    chk("frame starts", tgt, u_sink.n_fs);
  endtask

  // Checks the frame that just ended; p is the line period in clocks
  task automatic check_frame(input int p);
    int n;
    wait_fs(1);
    chk("frame", 32'(8 * p), u_sink.t_fs - u_sink.t_fs0);
    chk("top", 32'(p), u_sink.t_ls1 - u_sink.t_fs0);
    chk("end", 32'(5 * p), u_sink.t_fe - u_sink.t_fs0);
    chk("gap", 32'(p), u_sink.t_ls - u_sink.t_ls0);
    chk("active", 32'd2, u_sink.act);
    chk("bytes", 32'd16, u_sink.line_bytes);
    chk("header", 32'h95, {24'h0, u_sink.vc, u_sink.dt});
    for (int k = 0; k < 4; k++)
    begin
      n = 0;
      for (int j = 0; j < 16; j++)
        if (u_sink.idx[j] === 4'(k))
          n++;
      chk("bar", (k < 3) ? 32'd3 : 32'd7, 32'(n));
    end
  endtask

  initial
  begin
    repeat (20) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    for (int a = 1; a < 16; a++)
      rd(8'(a), rst_tab[a]);
    wr(8'h10, 8'h5A);
    rd(8'h10, 8'h00);
    for (int a = 2; a < 16; a++)
    begin
      wr(8'(a), set_tab[a]);
      rd(8'(a), set_tab[a]);
    end
    wr(VTPT_CTL_OFS, 8'h01);
    wait_fs(1);
    check_frame(635);
    wr(VTPT_PD_LO_OFS, 8'hC8);
    wr(VTPT_PD_HI_OFS, 8'h00);
    wait_fs(1);
    check_frame(40);
    wr(VTPT_BAR_LO_OFS, 8'h01);
    for (int s = 0; s < 4; s++)
    begin
      wr(VTPT_CFG_OFS, 8'(s * 16 + 3));
      wait_fs(2);
      chk("last bar", 32'((1 << s) - 1), {28'h0, u_sink.idx[15]});
    end
    // Two-byte fixed pattern: index repeats 0, 1 along the line
    wr(VTPT_CFG_OFS, 8'h82);
    wait_fs(2);
    chk("solid", 32'h0101,
      {16'h0, u_sink.idx[0], u_sink.idx[1], u_sink.idx[2], u_sink.idx[5]});
    wr(VTPT_CTL_OFS, 8'h00);
    repeat (3) @(posedge sys_clk_i);
    seen_ls = u_sink.n_ls;
    repeat (200) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    chk("stopped", seen_ls, u_sink.n_ls);
    chk("busy", 32'h0, {31'h0, frame_busy_o});
    give_verdict();
  end

  // About 9300 cycles are needed; allow plenty before calling it a hang
  initial
  begin
    repeat (40000) @(posedge sys_clk_i);
    n_fail++;
    $display("[ERR] run length expected 40000 cycles seen more");
    give_verdict();
  end
endmodule
